// [rtl/asr_cfg.svh]
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH
// clock of either end, in ns
`define ASR_SYS_PERIOD_NS 4
// longest conversion time; rounded down to whole cycles
`define ASR_CONV_TIME_NS 650
`define ASR_CONV_CYC (`ASR_CONV_TIME_NS / `ASR_SYS_PERIOD_NS)
// power-up time from power-down; rounded up
`define ASR_PWRUP_TIME_US 100
`define ASR_PWRUP_CYC ((`ASR_PWRUP_TIME_US * 1000 + `ASR_SYS_PERIOD_NS - 1) / `ASR_SYS_PERIOD_NS)
// quiet interval after a frame and least start-pulse low time; rounded up
`define ASR_QUIET_TIME_NS 60
`define ASR_QUIET_CYC ((`ASR_QUIET_TIME_NS + `ASR_SYS_PERIOD_NS - 1) / `ASR_SYS_PERIOD_NS)
`define ASR_START_LOW_NS 12
`define ASR_START_LOW_CYC ((`ASR_START_LOW_NS + `ASR_SYS_PERIOD_NS - 1) / `ASR_SYS_PERIOD_NS)
// extra host wait for synchroniser latency
`define ASR_CONV_MARGIN 8
// widths and frame lengths in serial clock cycles
`define ASR_RES_W 12
`define ASR_MSB_IDX 4'hb
`define ASR_CNT_W 5
`define ASR_TMR_W 16
`define ASR_BITS_BUSY 5'h0d
`define ASR_BITS_PLAIN 5'h0c
`define ASR_BITS_16 5'h10
`define ASR_BITS_RESET 5'h08
`define ASR_SHORT_MIN 5'h02
`define ASR_SHORT_MAX 5'h08
// host serial clock half period in cycles, less one
`define ASR_SCLK_HALF 3'h3
`endif

// [rtl/asr_pkg.sv]
`default_nettype none
package asr_pkg;
    typedef enum logic [2:0] {
        HS_IDLE = 3'h0,
        HS_PWRUP = 3'h1,
        HS_START = 3'h2,
        HS_CONV = 3'h3,
        HS_READ = 3'h4,
        HS_QUIET = 3'h5
    } asr_hstate_t;
endpackage
`default_nettype wire

// [rtl/asr_link_if.sv]
`default_nettype none
interface asr_link_if;
    logic conversion_start_n;
    logic cs_n;
    logic sclk;
    logic sdo;
    logic sdo_oe_n;
    wire logic sdo_line;
    // pull-up on the data line: released reads as high
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo;
    modport dev (
        input conversion_start_n,
        input cs_n,
        input sclk,
        output sdo,
        output sdo_oe_n
    );
    modport host (
        output conversion_start_n,
        output cs_n,
        output sclk,
        input sdo_line
    );
endinterface
`default_nettype wire

// [rtl/asr_dev.sv]
`include "asr_cfg.svh"
`default_nettype none
module asr_dev #(
    parameter int PWRUP_CYC = `ASR_PWRUP_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    asr_link_if.dev link,
    input wire logic [`ASR_RES_W-1:0] analog_i,
    output logic [`ASR_RES_W-1:0] result_o,
    output logic eoc_o,
    output logic converting_o,
    output logic powered_down_o,
    output logic powering_up_o,
    output logic busy_readout_o,
    output logic reset_needed_o,
    output logic soft_reset_o
);
    logic cv_s1_reg, cv_s2_reg, cv_d_reg;
    logic cs_s1_reg, cs_s2_reg, cs_d_reg;
    logic sk_s1_reg, sk_s2_reg, sk_d_reg;
    logic conv_reg;
    logic [`ASR_TMR_W-1:0] conv_cnt_reg;
    logic [`ASR_TMR_W-1:0] pwrup_cnt_reg;
    logic [`ASR_RES_W-1:0] hold_reg, result_reg;
    logic busy_en_reg, drive_reg, pd_reg, avail_reg, frame_read_reg;
    logic [`ASR_CNT_W-1:0] fall_cnt_reg;
    logic armed_reg, need_rst_reg, rst_done_reg, eoc_reg;
    logic [`ASR_CNT_W-1:0] bit_cnt_reg;
    logic end_reg;
    logic pu_reg;
    logic start_fall, start_rise, cs_rise, sk_fall, eoc;
    logic [`ASR_CNT_W-1:0] limit, idx;
    logic [3:0] pos;
    logic bit_val;

    // pins pass two flops before the oscillator-side logic reads them
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            {cv_s1_reg, cv_s2_reg, cv_d_reg} <= 3'h7;
            {cs_s1_reg, cs_s2_reg, cs_d_reg} <= 3'h7;
            {sk_s1_reg, sk_s2_reg, sk_d_reg} <= 3'h0;
        end else begin
            cv_s1_reg <= link.conversion_start_n;
            cv_s2_reg <= cv_s1_reg;
            cv_d_reg <= cv_s2_reg;
            cs_s1_reg <= link.cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_d_reg <= cs_s2_reg;
            sk_s1_reg <= link.sclk;
            sk_s2_reg <= sk_s1_reg;
            sk_d_reg <= sk_s2_reg;
        end
    end

    assign start_fall = cv_d_reg & ~cv_s2_reg;
    assign start_rise = ~cv_d_reg & cv_s2_reg;
    assign cs_rise = ~cs_d_reg & cs_s2_reg;
    assign sk_fall = sk_d_reg & ~sk_s2_reg;
    assign eoc = conv_reg && (conv_cnt_reg == '0);

    // conversion timer; a start during a conversion is ignored
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            conv_reg <= 1'b0;
            conv_cnt_reg <= '0;
            hold_reg <= '0;
        end else if (start_fall && !conv_reg) begin
            conv_reg <= 1'b1;
            hold_reg <= analog_i;
            conv_cnt_reg <= `ASR_TMR_W'(`ASR_CONV_CYC - 1);
        end else if (eoc) begin
            conv_reg <= 1'b0;
        end else if (conv_reg) begin
            conv_cnt_reg <= conv_cnt_reg - `ASR_TMR_W'(1);
        end
    end

    // result and readout mode change only at end of conversion
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            result_reg <= '0;
            busy_en_reg <= 1'b0;
            eoc_reg <= 1'b0;
        end else begin
            eoc_reg <= eoc;
            if (eoc) begin
                result_reg <= hold_reg;
                busy_en_reg <= ~cs_s2_reg;
            end
        end
    end

    // busy mode drives low from end of conversion while select is low
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            drive_reg <= 1'b0;
        end else if (eoc && !cs_s2_reg) begin
            drive_reg <= 1'b1;
        end else if (cs_s2_reg) begin
            drive_reg <= 1'b0;
        end
    end

    // power-down sampled at end; a start rise begins the settle timer
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pd_reg <= 1'b0;
            pwrup_cnt_reg <= '0;
            pu_reg <= 1'b0;
        end else begin
            if (eoc) begin
                pd_reg <= ~cv_s2_reg;
            end else if (start_rise && pd_reg) begin
                pd_reg <= 1'b0;
                pwrup_cnt_reg <= `ASR_TMR_W'(PWRUP_CYC);
                pu_reg <= 1'b1;
            end else if (pwrup_cnt_reg != '0) begin
                pwrup_cnt_reg <= pwrup_cnt_reg - `ASR_TMR_W'(1);
                pu_reg <= (pwrup_cnt_reg != `ASR_TMR_W'(1)); // flop mirrors count != 0
            end
        end
    end

    // counts clock falls of a read frame to spot a short-cycled read
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            fall_cnt_reg <= '0;
            avail_reg <= 1'b0;
            frame_read_reg <= 1'b0;
        end else begin
            if (eoc) begin
                avail_reg <= 1'b1;
            end else if (cs_rise) begin
                avail_reg <= 1'b0;
            end
            if (cs_s2_reg) begin
                fall_cnt_reg <= '0;
                frame_read_reg <= avail_reg;
            end else if (sk_fall && fall_cnt_reg != '1) begin
                fall_cnt_reg <= fall_cnt_reg + `ASR_CNT_W'(1);
            end
        end
    end

    // soft reset: armed by a short read, executed at the next end
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            armed_reg <= 1'b0;
            need_rst_reg <= 1'b1;
            rst_done_reg <= 1'b0;
        end else begin
            rst_done_reg <= eoc && armed_reg;
            if (eoc && armed_reg) begin
                armed_reg <= 1'b0;
                need_rst_reg <= 1'b0;
            end else if (cs_rise && frame_read_reg && fall_cnt_reg >= `ASR_SHORT_MIN
                         && fall_cnt_reg <= `ASR_SHORT_MAX) begin
                armed_reg <= 1'b1;
            end
        end
    end

    // link side: counts falls of the serial clock; select high clears it at once
    // because the serial clock stops between frames
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            bit_cnt_reg <= '0;
            end_reg <= 1'b0;
        end else if (!end_reg) begin
            bit_cnt_reg <= bit_cnt_reg + `ASR_CNT_W'(1);
            end_reg <= (bit_cnt_reg + `ASR_CNT_W'(1)) == limit;
        end
    end

    // busy mode spends the first fall on the low indicator
    assign limit = busy_en_reg ? `ASR_BITS_BUSY : `ASR_BITS_PLAIN;
    assign idx = busy_en_reg ? bit_cnt_reg - `ASR_CNT_W'(1) : bit_cnt_reg;
    assign pos = `ASR_MSB_IDX - idx[3:0];
    always_comb begin
        bit_val = 1'b0;
        if (busy_en_reg && bit_cnt_reg == '0) begin
            bit_val = 1'b0;
        end else if (idx <= `ASR_CNT_W'(`ASR_MSB_IDX)) begin
            bit_val = result_reg[pos];
        end
    end

    // result is quiet during a frame, so the word is read across domains
    // without a handshake; the host keeps the quiet interval to make it so
    assign link.sdo = bit_val;
    assign link.sdo_oe_n = link.cs_n | end_reg | (busy_en_reg & ~drive_reg);

    // user-side status, all from flops
    assign result_o = result_reg;
    assign eoc_o = eoc_reg;
    assign converting_o = conv_reg;
    assign powered_down_o = pd_reg;
    assign powering_up_o = pu_reg;
    assign busy_readout_o = busy_en_reg;
    assign reset_needed_o = need_rst_reg;
    assign soft_reset_o = rst_done_reg;
endmodule
`default_nettype wire

// [rtl/asr_host.sv]
`include "asr_cfg.svh"
`default_nettype none
module asr_host #(
    parameter int PWRUP_CYC = `ASR_PWRUP_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    asr_link_if.host link,
    input wire logic start_i,
    input wire logic busy_mode_i,
    input wire logic frame16_i,
    input wire logic soft_reset_i,
    input wire logic power_down_i,
    output logic ready_o,
    output logic [`ASR_RES_W-1:0] result_o,
    output logic result_valid_o,
    output logic powered_down_o
);
    asr_pkg::asr_hstate_t state_reg;
    logic cv_reg, cs_reg, sclk_reg;
    logic sd_s1_reg, sd_s2_reg;
    logic busy_reg, f16_reg, rst_reg, pd_opt_reg, pd_reg, busy_ok_reg, valid_reg;
    logic [`ASR_TMR_W-1:0] tmr_reg;
    logic [2:0] half_reg;
    logic [`ASR_CNT_W-1:0] falls_reg, rises_reg, nbits;
    logic [`ASR_RES_W-1:0] sh_reg;
    logic tick;
    logic pulse_reg, ready_reg;

    // data line from the far end passes two flops
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            sd_s1_reg <= 1'b1;
            sd_s2_reg <= 1'b1;
        end else begin
            sd_s1_reg <= link.sdo_line;
            sd_s2_reg <= sd_s1_reg;
        end
    end

    // reset reads 8 clocks; otherwise the frame length asked for
    assign nbits = rst_reg ? `ASR_BITS_RESET : f16_reg ? `ASR_BITS_16 :
                   busy_reg ? `ASR_BITS_BUSY : `ASR_BITS_PLAIN;
    assign tick = (half_reg == 3'h0);

    // sequencer: power-up, start pulse, conversion wait, read, quiet
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state_reg <= asr_pkg::HS_IDLE;
            cv_reg <= 1'b1;
            cs_reg <= 1'b1;
            sclk_reg <= 1'b0;
            tmr_reg <= '0;
            half_reg <= '0;
            falls_reg <= '0;
            rises_reg <= '0;
            sh_reg <= '0;
            {busy_reg, f16_reg, rst_reg, pd_opt_reg, pd_reg, busy_ok_reg} <= 6'h00;
            valid_reg <= 1'b0;
            pulse_reg <= 1'b0;
            ready_reg <= 1'b1;
        end else begin
            valid_reg <= 1'b0;
            unique case (state_reg)
                asr_pkg::HS_IDLE: begin
                    if (start_i) begin
                        ready_reg <= 1'b0;
                        busy_reg <= busy_mode_i;
                        f16_reg <= frame16_i;
                        rst_reg <= soft_reset_i;
                        pd_opt_reg <= power_down_i;
                        busy_ok_reg <= busy_ok_reg & busy_mode_i;
                        if (pd_reg) begin
                            cv_reg <= 1'b1;
                            tmr_reg <= `ASR_TMR_W'(PWRUP_CYC);
                            state_reg <= asr_pkg::HS_PWRUP;
                        end else begin
                            state_reg <= asr_pkg::HS_START;
                        end
                    end
                end
                asr_pkg::HS_PWRUP: begin
                    pd_reg <= 1'b0;
                    if (tmr_reg == '0) begin
                        state_reg <= asr_pkg::HS_START;
                    end else begin
                        tmr_reg <= tmr_reg - `ASR_TMR_W'(1);
                    end
                end
                asr_pkg::HS_START: begin
                    // start pulse low; select is set to choose the mode
                    cv_reg <= 1'b0;
                    pulse_reg <= 1'b1;
                    cs_reg <= ~busy_reg;
                    tmr_reg <= `ASR_TMR_W'(`ASR_START_LOW_CYC);
                    state_reg <= asr_pkg::HS_CONV;
                    rises_reg <= '0;
                    falls_reg <= '0;
                    half_reg <= `ASR_SCLK_HALF;
                end
                asr_pkg::HS_CONV: begin
                    // pulse phase tracked apart, as power-down keeps start low after it
                    if (pulse_reg && tmr_reg == `ASR_TMR_W'(1)) begin
                        pulse_reg <= 1'b0;
                        cv_reg <= ~pd_opt_reg;
                        tmr_reg <= `ASR_TMR_W'(`ASR_CONV_CYC + `ASR_CONV_MARGIN);
                    end else if (!pulse_reg && (tmr_reg == '0 || (busy_ok_reg
                                 && !sd_s2_reg))) begin
                        // busy indicator trusted only after the first busy read
                        cs_reg <= 1'b0;
                        state_reg <= asr_pkg::HS_READ;
                    end else begin
                        tmr_reg <= tmr_reg - `ASR_TMR_W'(1);
                    end
                end
                asr_pkg::HS_READ: begin
                    half_reg <= tick ? `ASR_SCLK_HALF : half_reg - 3'h1;
                    if (tick && falls_reg != nbits) begin
                        sclk_reg <= ~sclk_reg;
                        if (!sclk_reg) begin
                            rises_reg <= rises_reg + `ASR_CNT_W'(1);
                            // only the twelve data rises are kept: busy mode drops the
                            // leading low sample, 16-bit frames drop the released tail
                            if (busy_reg ? (rises_reg != '0 && rises_reg <= `ASR_BITS_PLAIN)
                                         : (rises_reg < `ASR_BITS_PLAIN)) begin
                                sh_reg <= {sh_reg[`ASR_RES_W-2:0], sd_s2_reg};
                            end
                        end else begin
                            falls_reg <= falls_reg + `ASR_CNT_W'(1);
                        end
                    end else if (tick) begin
                        cs_reg <= 1'b1;
                        tmr_reg <= `ASR_TMR_W'(`ASR_QUIET_CYC);
                        state_reg <= asr_pkg::HS_QUIET;
                    end
                end
                asr_pkg::HS_QUIET: begin
                    // quiet interval counts from select going high, one half period after the last clock
                    if (tmr_reg == '0) begin
                        valid_reg <= ~rst_reg;
                        busy_ok_reg <= busy_reg;
                        pd_reg <= pd_opt_reg;
                        ready_reg <= 1'b1;
                        state_reg <= asr_pkg::HS_IDLE;
                    end else begin
                        tmr_reg <= tmr_reg - `ASR_TMR_W'(1);
                    end
                end
                default: begin
                    ready_reg <= 1'b1;
                    state_reg <= asr_pkg::HS_IDLE;
                end
            endcase
        end
    end

    assign link.conversion_start_n = cv_reg;
    assign link.cs_n = cs_reg;
    assign link.sclk = sclk_reg;
    assign ready_o = ready_reg;
    assign result_o = sh_reg;
    assign result_valid_o = valid_reg;
    assign powered_down_o = pd_reg;
endmodule
`default_nettype wire

// [sim/asr_link_assertions.sv]
`default_nettype none
module asr_link_checker (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic conversion_start_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdo_oe_n,
    input wire logic sdo_line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sclk_reg;
    logic cs_reg;
    logic start_reg;
    logic [4:0] n_fall_reg;
    logic [7:0] since_start_reg;
    logic plain_reg;
    logic busy_reg;
    logic busy_prev_reg;
    default clocking dclk @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // falls of the serial clock inside one frame, counted at the pins
    always_ff @(posedge sys_clk_i) begin
        sclk_reg <= sclk;
        cs_reg <= cs_n;
        if (cs_n)
            n_fall_reg <= 5'h00;
        else if (sclk_reg && !sclk && n_fall_reg != 5'h1f)
            n_fall_reg <= n_fall_reg + 5'h01;
    end
    // cycles since start fell; saturates so long idles cannot wrap into a window
    always_ff @(posedge sys_clk_i) begin
        start_reg <= conversion_start_n;
        if (!rst_b_i)
            since_start_reg <= 8'hff;
        else if (start_reg && !conversion_start_n)
            since_start_reg <= 8'h00;
        else if (since_start_reg != 8'hff)
            since_start_reg <= since_start_reg + 8'h01;
    end
    // frame class: select falling after the end means plain, before it means busy;
    // the first busy frame is never trusted, so busy checks need two in a row
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            plain_reg <= 1'b0;
            busy_reg <= 1'b0;
            busy_prev_reg <= 1'b0;
        end else if (!cs_n && start_reg && !conversion_start_n) begin
            // select may fall in the same cycle as start: that is a busy frame too
            plain_reg <= 1'b0;
            busy_reg <= 1'b1;
        end else if (cs_reg && !cs_n) begin
            plain_reg <= since_start_reg > 8'ha7;
            busy_reg <= since_start_reg < 8'h8c;
        end else if (!cs_reg && cs_n) begin
            busy_prev_reg <= busy_reg;
        end
    end
    property p_release_deselect; cs_n |-> sdo_oe_n; endproperty
    a_release_deselect: assert property (p_release_deselect)
        else $error("data line driven while deselected");
    // clock still high means the counted fall is not yet followed by the next one
    property p_plain_hold;
        plain_reg && !cs_n && sclk && n_fall_reg == 5'h0b |-> !sdo_oe_n;
    endproperty
    a_plain_hold: assert property (p_plain_hold)
        else $error("plain frame released before last bit");
    property p_plain_release; plain_reg && n_fall_reg == 5'h0c |-> ##[0:4] sdo_oe_n; endproperty
    a_plain_release: assert property (p_plain_release)
        else $error("plain frame not released after twelfth fall");
    property p_tail_release; n_fall_reg > 5'h0c |-> ##[0:4] sdo_oe_n; endproperty
    a_tail_release: assert property (p_tail_release)
        else $error("data line driven in trailing clocks");
    property p_busy_hold;
        busy_reg && busy_prev_reg && !cs_n && sclk && n_fall_reg == 5'h0c |-> !sdo_oe_n;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy frame released before thirteenth fall");
    property p_busy_low;
        busy_reg && busy_prev_reg && !cs_n && sclk && n_fall_reg == 5'h00 && !sdo_oe_n
            && since_start_reg > 8'ha7 && since_start_reg < 8'hc8 |-> !sdo_line;
    endproperty
    a_busy_low: assert property (p_busy_low)
        else $error("busy indication not low before first fall");
    property p_busy_tristate;
        busy_reg && busy_prev_reg && !cs_n && since_start_reg inside {[8'h08:8'h90]}
            |-> sdo_oe_n;
    endproperty
    a_busy_tristate: assert property (p_busy_tristate)
        else $error("data line driven during busy conversion");
    property p_stable_high; sclk && sclk_reg && !cs_n |-> $stable(sdo_line); endproperty
    a_stable_high: assert property (p_stable_high)
        else $error("data changed while serial clock high");
    property p_idle_low; $fell(cs_n) |-> !sclk; endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("serial clock not idle low at select fall");
    property p_quiet_gap; $rose(cs_n) && conversion_start_n |-> conversion_start_n [*8]; endproperty
    a_quiet_gap: assert property (p_quiet_gap)
        else $error("start lowered inside quiet interval");
endmodule
`default_nettype wire

// [sim/adc_serial_readout_control_test.sv]
`default_nettype none
module adc_serial_readout_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PWRUP = 50;
    localparam logic [5:0] CORNER_BUSY = 6'h1b;
    localparam logic [5:0] CORNER_F16 = 6'h2c;
    logic sys_clk_i, dev_clk, rst_b_i;
    logic start_i, busy_mode_i, frame16_i, soft_reset_i, power_down_i;
    logic ready_o, result_valid_o, powered_down_o;
    logic [11:0] result_o, analog_i, d_result, got_word;
    logic d_conv, d_pd, d_pu, d_busy, d_rn, d_sr, got_valid, seen_pu, seen_sr;
    logic d_eoc;
    logic [31:0] seed = 32'h000182df;
    logic [11:0] corner_val [4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
    int n_mismatch = 0;
    int tests_run = 0;
    int conv_len;
    int n_eoc;
    // device oscillator shares the rate but not the phase of the host clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        dev_clk = 1'b0;
        #1.3;
        forever #2 dev_clk = ~dev_clk;
    end
    asr_link_if link ();
    asr_host #(.PWRUP_CYC(PWRUP)) i_asr_host (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .link(link), .start_i(start_i), .busy_mode_i(busy_mode_i), .frame16_i(frame16_i),
        .soft_reset_i(soft_reset_i), .power_down_i(power_down_i), .ready_o(ready_o),
        .result_o(result_o), .result_valid_o(result_valid_o), .powered_down_o(powered_down_o));
    asr_dev #(.PWRUP_CYC(PWRUP)) i_asr_dev (.sys_clk_i(dev_clk), .rst_b_i(rst_b_i),
        .link(link), .analog_i(analog_i), .result_o(d_result), .eoc_o(d_eoc),
        .converting_o(d_conv), .powered_down_o(d_pd), .powering_up_o(d_pu),
        .busy_readout_o(d_busy), .reset_needed_o(d_rn), .soft_reset_o(d_sr));
    asr_link_checker i_asr_link_checker (.sys_clk_i(dev_clk), .rst_b_i(rst_b_i),
        .conversion_start_n(link.conversion_start_n), .cs_n(link.cs_n), .sclk(link.sclk),
        .sdo_oe_n(link.sdo_oe_n), .sdo_line(link.sdo_line));
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    // one host transaction; analog input flips once converting so a late sample shows
    task automatic run_op(input logic busy, input logic f16, input logic sr, input logic pd,
                          input logic [11:0] val);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 4000) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (n >= 4000) begin
            n_mismatch++;
            conclude();
        end
        analog_i = val;
        busy_mode_i = busy;
        frame16_i = f16;
        soft_reset_i = sr;
        power_down_i = pd;
        start_i = 1'b1;
        @(negedge sys_clk_i);
        start_i = 1'b0;
        got_valid = 1'b0;
        seen_pu = 1'b0;
        seen_sr = 1'b0;
        conv_len = 0;
        n_eoc = 0;
        n = 0;
        while (n < 4000 && (n < 4 || ready_o !== 1'b1)) begin
            @(negedge sys_clk_i);
            n++;
            if (d_conv === 1'b1 && conv_len == 0)
                analog_i = ~val;
            if (d_conv === 1'b1)
                conv_len++;
            if (d_pu === 1'b1)
                seen_pu = 1'b1;
            if (d_sr === 1'b1)
                seen_sr = 1'b1;
            if (d_eoc === 1'b1)
                n_eoc++;
            if (result_valid_o === 1'b1) begin
                got_valid = 1'b1;
                got_word = result_o;
            end
        end
        if (n >= 4000) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic check_op(input logic busy, input logic sr, input logic pd,
                            input logic [11:0] val);
        if (!sr) begin
            chk_bit("result_valid", 1'b1, got_valid);
            chk_word("host_result", val, got_word);
            chk_word("dev_result", val, d_result);
        end
        chk_bit("conv_time", 1'b1, conv_len > 0 && conv_len <= 163);
        chk_bit("eoc_pulse", 1'b1, n_eoc == 1);
        chk_bit("busy_readout", busy, d_busy);
        chk_bit("dev_powered_down", pd, d_pd);
        chk_bit("host_powered_down", pd, powered_down_o);
    endtask
    // main sequence: soft reset first, then corners, random mix, power-down
    initial begin
        logic b;
        logic f;
        logic [11:0] v;
        rst_b_i = 1'b0;
        start_i = 1'b0;
        busy_mode_i = 1'b0;
        frame16_i = 1'b0;
        soft_reset_i = 1'b0;
        power_down_i = 1'b0;
        analog_i = 12'h000;
        repeat (5) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        chk_bit("reset_needed", 1'b1, d_rn);
        run_op(1'b0, 1'b0, 1'b1, 1'b0, 12'h5a5);
        check_op(1'b0, 1'b1, 1'b0, 12'h5a5);
        run_op(1'b0, 1'b0, 1'b0, 1'b0, 12'h3c3);
        chk_bit("soft_reset_pulse", 1'b1, seen_sr);
        chk_bit("reset_needed", 1'b0, d_rn);
        check_op(1'b0, 1'b0, 1'b0, 12'h3c3);
        for (int i = 0; i < 16; i++) begin
            seed = xorshift(seed);
            b = (i < 6) ? CORNER_BUSY[i] : seed[0];
            f = (i < 6) ? CORNER_F16[i] : seed[1];
            v = (i < 4) ? corner_val[i] : seed[13:2];
            run_op(b, f, 1'b0, 1'b0, v);
            check_op(b, 1'b0, 1'b0, v);
        end
        run_op(1'b0, 1'b0, 1'b0, 1'b1, 12'h0f0);
        check_op(1'b0, 1'b0, 1'b1, 12'h0f0);
        run_op(1'b1, 1'b0, 1'b0, 1'b0, 12'ha5a);
        chk_bit("powering_up", 1'b1, seen_pu);
        check_op(1'b1, 1'b0, 1'b0, 12'ha5a);
        conclude();
    end
endmodule
`default_nettype wire
